// File: inc/rfc_defines.svh
`ifndef RFC_DEFINES_SVH
`define RFC_DEFINES_SVH

// ==========================================================
// Widths and counts
`define RFC_W         32
`define RFC_EW        80
`define RFC_NG        16
`define RFC_NE        4
`define RFC_NL        16
`define RFC_NF        4
`define RFC_RIW       4
`define RFC_EIW       2
`define RFC_FIW       2
`define RFC_CNTW      3
`define RFC_DEPW      8
`define RFC_MAXW      4
`define RFC_LENW      2
`define RFC_OFFW      12
`define RFC_SCW       3
`define RFC_BYTE_SH   2

// ==========================================================
// Fixed indices and limits
`define RFC_FP_IDX    4'hf
`define RFC_LINK_IDX  4'h0
`define RFC_LAST_WORD 4'hf
`define RFC_FULL      3'h4
`define RFC_ONE       3'h1
`define RFC_MAX_SCALE 3'h4
`define RFC_B8        8
`define RFC_B16       16

`endif

// File: inc/rfc_pkg.sv
`include "rfc_defines.svh"

package rfc_pkg;

  // ========================================================
  // Enumerations
  typedef enum logic [1:0] {RFC_OP_NONE, RFC_OP_CALL, RFC_OP_RET, RFC_OP_FLUSH} rfc_op_t;
  typedef enum logic [1:0] {RFC_ST_IDLE, RFC_ST_SPILL, RFC_ST_FILL} rfc_st_t;
  typedef enum logic [2:0] {
    RFC_AM_ABS12, RFC_AM_ABS32, RFC_AM_IND, RFC_AM_IND12,
    RFC_AM_IND32, RFC_AM_IDX, RFC_AM_SC_DISP, RFC_AM_IDX_DISP
  } rfc_amode_t;
  typedef enum logic [2:0] {
    RFC_TY_WORD, RFC_TY_U8, RFC_TY_S8, RFC_TY_U16, RFC_TY_S16
  } rfc_type_t;

  // ========================================================
  // Carriers
  typedef struct packed {
    logic [`RFC_RIW:0]    addr;
    logic [`RFC_LENW-1:0] len;
    rfc_type_t            ty;
  } rfc_rd_t;

  typedef struct packed {
    logic                                en;
    logic [`RFC_RIW:0]                   addr;
    logic [`RFC_LENW-1:0]                len;
    logic [`RFC_MAXW-1:0][`RFC_W-1:0]    data;
  } rfc_wr_t;

  typedef struct packed {
    logic                 req;
    logic                 we;
    logic [`RFC_W-1:0]    addr;
    logic [`RFC_W-1:0]    wdata;
  } rfc_mem_t;

  typedef struct packed {
    rfc_amode_t           mode;
    logic [`RFC_SCW-1:0]  scale;
    logic [`RFC_OFFW-1:0] off12;
    logic [`RFC_W-1:0]    disp;
    logic [`RFC_RIW:0]    base_sel;
    logic [`RFC_RIW:0]    idx_sel;
  } rfc_ag_t;

  typedef struct packed {
    logic [`RFC_W-1:0] ea;
    logic              valid;
    logic              fault;
  } rfc_ag_st_t;

  typedef struct packed {
    logic [`RFC_NG-1:0][`RFC_W-1:0]                 glob;
    logic [`RFC_NE-1:0][`RFC_EW-1:0]                ext;
    logic [`RFC_NF-1:0][`RFC_NL-1:0][`RFC_W-1:0]    loc;
    logic [`RFC_NF-1:0][`RFC_W-1:0]                 base;
    logic [`RFC_FIW-1:0]                            cur;
    logic [`RFC_CNTW-1:0]                           cached;
    logic [`RFC_DEPW-1:0]                           depth;
    rfc_st_t                                        st;
    rfc_op_t                                        pend;
    logic [`RFC_FIW-1:0]                            slot;
    logic [`RFC_RIW-1:0]                            wcnt;
    rfc_mem_t                                       mem;
    logic [`RFC_MAXW-1:0][`RFC_W-1:0]               rd_a;
    logic [`RFC_MAXW-1:0][`RFC_W-1:0]               rd_b;
    logic [`RFC_EW-1:0]                             ext_rd;
    logic                                           busy;
    logic                                           under;
  } rfc_state_t;

endpackage

// File: rtl/rfc_agen.sv
`timescale 1ns/10ps
`include "rfc_defines.svh"

module rfc_agen
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // Request
  input  wire logic              valid_in,
  input  wire rfc_pkg::rfc_ag_t  req_in,
  input  wire logic [`RFC_W-1:0] base_val_in,
  input  wire logic [`RFC_W-1:0] idx_val_in,
  // Result
  output logic [`RFC_W-1:0]      ea_out,
  output logic                   valid_out,
  output logic                   fault_out
);

  rfc_pkg::rfc_ag_st_t s_q;
  rfc_pkg::rfc_ag_st_t s_d;

  // ========================================================
  // Effective address
  always_comb
  begin
    logic [`RFC_W-1:0] scaled;
    logic [`RFC_W-1:0] off;
    scaled = idx_val_in << req_in.scale;
    off    = {{(`RFC_W-`RFC_OFFW){1'b0}}, req_in.off12};
    s_d = s_q;
    s_d.valid = valid_in;
    s_d.fault = valid_in && (req_in.scale > `RFC_MAX_SCALE);
    unique case (req_in.mode)
      rfc_pkg::RFC_AM_ABS12:    s_d.ea = off;
      rfc_pkg::RFC_AM_ABS32:    s_d.ea = req_in.disp;
      rfc_pkg::RFC_AM_IND:      s_d.ea = base_val_in;
      rfc_pkg::RFC_AM_IND12:    s_d.ea = base_val_in + off;
      rfc_pkg::RFC_AM_IND32:    s_d.ea = base_val_in + req_in.disp;
      rfc_pkg::RFC_AM_IDX:      s_d.ea = base_val_in + scaled;
      rfc_pkg::RFC_AM_SC_DISP:  s_d.ea = scaled + req_in.disp;
      rfc_pkg::RFC_AM_IDX_DISP: s_d.ea = base_val_in + scaled + req_in.disp;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign ea_out    = s_q.ea;
  assign valid_out = s_q.valid;
  assign fault_out = s_q.fault;

  // ========================================================
  // Checks
  AST_BAD_SCALE: assert property (@(posedge clk_in) disable iff (rst_in)
    valid_in && req_in.scale > `RFC_MAX_SCALE |=> fault_out && valid_out)
    else $error("illegal scale not flagged");
  AST_IDX_DISP_EA: assert property (@(posedge clk_in) disable iff (rst_in)
    valid_in && req_in.mode == rfc_pkg::RFC_AM_IDX_DISP |=>
      ea_out == $past(base_val_in) + ($past(idx_val_in) << $past(req_in.scale))
                + $past(req_in.disp))
    else $error("indexed displacement address wrong");

endmodule

// File: rtl/rfc_top.sv
`timescale 1ns/10ps
`include "rfc_defines.svh"

// Contract
// - Sixteen 32-bit global registers, indices 0 to 15.
// - Four 80-bit extended registers, indices 0 to 3.
// - Calls never save or swap global or extended registers.
// - Each call gets a fresh private set of sixteen 32-bit locals.
// - Up to four local frames cached on chip, three calls without memory.
// - Call with four frames cached spills the oldest frame to memory.
// - Global 15 is the frame pointer into the memory stack.
// - Any register may hold single or double operands; extended registers for 80-bit.
// - One flat byte address space of 2^32 bytes.
// - Absolute, indirect, offset, scaled index and displacement address forms.
// - Scale factor limited to 1, 2, 4, 8 or 16.
// - Signed and unsigned 8/16/32/64-bit integers, 32/64/80-bit reals.
// - Bit, bit field, triple and quad word operands supported.
module rfc_top
(
  // Clock and reset
  input  wire logic                             CLK_IN,
  input  wire logic                             RST_IN,
  // Frame operations
  input  wire logic                             OP_VALID_IN,
  input  wire rfc_pkg::rfc_op_t                 OP_IN,
  output logic                                  BUSY_OUT,
  output logic                                  UNDERFLOW_OUT,
  output logic [`RFC_W-1:0]                     FRAME_POINTER_OUT,
  // Register ports
  input  wire rfc_pkg::rfc_rd_t                 RD_A_IN,
  output logic [`RFC_MAXW-1:0][`RFC_W-1:0]      RD_A_DATA_OUT,
  input  wire rfc_pkg::rfc_rd_t                 RD_B_IN,
  output logic [`RFC_MAXW-1:0][`RFC_W-1:0]      RD_B_DATA_OUT,
  input  wire rfc_pkg::rfc_wr_t                 WR_IN,
  // Extended registers
  input  wire logic [`RFC_EIW-1:0]              EXT_RD_IDX_IN,
  output logic [`RFC_EW-1:0]                    EXT_RD_DATA_OUT,
  input  wire logic                             EXT_WR_EN_IN,
  input  wire logic [`RFC_EIW-1:0]              EXT_WR_IDX_IN,
  input  wire logic [`RFC_EW-1:0]               EXT_WR_DATA_IN,
  // Address generation
  input  wire logic                             AG_VALID_IN,
  input  wire rfc_pkg::rfc_ag_t                 AG_IN,
  output logic [`RFC_W-1:0]                     AG_EA_OUT,
  output logic                                  AG_VALID_OUT,
  output logic                                  AG_FAULT_OUT,
  // Procedure stack memory
  output rfc_pkg::rfc_mem_t                     MEM_OUT,
  input  wire logic                             MEM_ACK_IN,
  input  wire logic [`RFC_W-1:0]                MEM_RDATA_IN
);

  rfc_pkg::rfc_state_t s_q;
  rfc_pkg::rfc_state_t s_d;

  // ==========================================================
  // Helpers
  function automatic logic [`RFC_W-1:0] word_of(input rfc_pkg::rfc_state_t x,
                                                input logic [`RFC_RIW:0] sel);
    if (sel[`RFC_RIW])
      return x.glob[sel[`RFC_RIW-1:0]];
    return x.loc[x.cur][sel[`RFC_RIW-1:0]];
  endfunction

  function automatic logic [`RFC_W-1:0] extend(input rfc_pkg::rfc_type_t ty,
                                               input logic [`RFC_W-1:0] w);
    unique case (ty)
      rfc_pkg::RFC_TY_U8:  return {{(`RFC_W-`RFC_B8){1'b0}}, w[`RFC_B8-1:0]};
      rfc_pkg::RFC_TY_S8:  return {{(`RFC_W-`RFC_B8){w[`RFC_B8-1]}}, w[`RFC_B8-1:0]};
      rfc_pkg::RFC_TY_U16: return {{(`RFC_W-`RFC_B16){1'b0}}, w[`RFC_B16-1:0]};
      rfc_pkg::RFC_TY_S16: return {{(`RFC_W-`RFC_B16){w[`RFC_B16-1]}}, w[`RFC_B16-1:0]};
      default:             return w;
    endcase
  endfunction

  // Groups stay inside one bank; index wraps within the bank
  function automatic logic [`RFC_MAXW-1:0][`RFC_W-1:0] read_group(
    input rfc_pkg::rfc_state_t x, input rfc_pkg::rfc_rd_t r);
    logic [`RFC_MAXW-1:0][`RFC_W-1:0] g;
    logic [`RFC_RIW-1:0]              idx;
    g = '0;
    for (int i = 0; i < `RFC_MAXW; i++)
    begin
      idx = r.addr[`RFC_RIW-1:0] + i[`RFC_RIW-1:0];
      if (i <= int'(r.len))
        g[i] = word_of(x, {r.addr[`RFC_RIW], idx});
    end
    g[0] = extend(r.ty, g[0]);
    return g;
  endfunction

  function automatic rfc_pkg::rfc_state_t do_call(input rfc_pkg::rfc_state_t x,
                                                  input logic [`RFC_W-1:0] fp);
    logic [`RFC_FIW-1:0] nxt;
    nxt = x.cur + 1'b1;
    x.base[x.cur]            = fp;
    x.loc[nxt]               = '0;
    x.loc[nxt][`RFC_LINK_IDX] = fp;
    x.cur                    = nxt;
    x.cached                 = x.cached + 1'b1;
    x.depth                  = x.depth + 1'b1;
    return x;
  endfunction

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [`RFC_RIW-1:0] widx;
    logic [`RFC_W-1:0]   woff;
    widx = '0;
    woff = {{(`RFC_W-`RFC_RIW-`RFC_BYTE_SH){1'b0}}, s_q.wcnt, {`RFC_BYTE_SH{1'b0}}};
    s_d = s_q;
    s_d.under = 1'b0;
    for (int i = 0; i < `RFC_MAXW; i++)
    begin
      widx = WR_IN.addr[`RFC_RIW-1:0] + i[`RFC_RIW-1:0];
      if (WR_IN.en && i <= int'(WR_IN.len))
      begin
        if (WR_IN.addr[`RFC_RIW])
          s_d.glob[widx] = WR_IN.data[i];
        else if (!s_q.busy)
          s_d.loc[s_q.cur][widx] = WR_IN.data[i];
      end
    end
    if (EXT_WR_EN_IN)
      s_d.ext[EXT_WR_IDX_IN] = EXT_WR_DATA_IN;
    s_d.ext_rd = s_q.ext[EXT_RD_IDX_IN];
    s_d.rd_a   = read_group(s_q, RD_A_IN);
    s_d.rd_b   = read_group(s_q, RD_B_IN);

    unique case (s_q.st)
      rfc_pkg::RFC_ST_IDLE:
      begin
        if (OP_VALID_IN)
        begin
          unique case (OP_IN)
            rfc_pkg::RFC_OP_NONE:
            begin
            end
            rfc_pkg::RFC_OP_CALL:
            begin
              if (s_q.cached == `RFC_FULL)
              begin
                s_d.st   = rfc_pkg::RFC_ST_SPILL;
                s_d.pend = rfc_pkg::RFC_OP_CALL;
                s_d.slot = s_q.cur + 1'b1;
                s_d.wcnt = '0;
              end
              else
                s_d = do_call(s_d, s_q.glob[`RFC_FP_IDX]);
            end
            rfc_pkg::RFC_OP_RET:
            begin
              if (s_q.depth == '0)
                s_d.under = 1'b1;
              else if (s_q.cached > `RFC_ONE)
              begin
                s_d.cur    = s_q.cur - 1'b1;
                s_d.cached = s_q.cached - 1'b1;
                s_d.depth  = s_q.depth - 1'b1;
              end
              else
              begin
                s_d.base[s_q.cur - 1'b1] = s_q.loc[s_q.cur][`RFC_LINK_IDX];
                s_d.cur   = s_q.cur - 1'b1;
                s_d.slot  = s_q.cur - 1'b1;
                s_d.depth = s_q.depth - 1'b1;
                s_d.wcnt  = '0;
                s_d.st    = rfc_pkg::RFC_ST_FILL;
              end
            end
            rfc_pkg::RFC_OP_FLUSH:
            begin
              if (s_q.cached > `RFC_ONE)
              begin
                s_d.st   = rfc_pkg::RFC_ST_SPILL;
                s_d.pend = rfc_pkg::RFC_OP_FLUSH;
                s_d.slot = s_q.cur - (s_q.cached[`RFC_FIW-1:0] - 1'b1);
                s_d.wcnt = '0;
              end
            end
          endcase
        end
      end
      rfc_pkg::RFC_ST_SPILL:
      begin
        if (!s_q.mem.req)
        begin
          s_d.mem.req   = 1'b1;
          s_d.mem.we    = 1'b1;
          s_d.mem.addr  = s_q.base[s_q.slot] + woff;
          s_d.mem.wdata = s_q.loc[s_q.slot][s_q.wcnt];
        end
        else if (MEM_ACK_IN)
        begin
          s_d.mem.req = 1'b0;
          s_d.wcnt    = s_q.wcnt + 1'b1;
          if (s_q.wcnt == `RFC_LAST_WORD)
          begin
            s_d.cached = s_q.cached - 1'b1;
            s_d.slot   = s_q.slot + 1'b1;
            if (s_q.pend == rfc_pkg::RFC_OP_CALL)
            begin
              s_d      = do_call(s_d, s_q.glob[`RFC_FP_IDX]);
              s_d.st   = rfc_pkg::RFC_ST_IDLE;
              s_d.pend = rfc_pkg::RFC_OP_NONE;
            end
            else if (s_d.cached == `RFC_ONE)
            begin
              s_d.st   = rfc_pkg::RFC_ST_IDLE;
              s_d.pend = rfc_pkg::RFC_OP_NONE;
            end
          end
        end
      end
      rfc_pkg::RFC_ST_FILL:
      begin
        if (!s_q.mem.req)
        begin
          s_d.mem.req   = 1'b1;
          s_d.mem.we    = 1'b0;
          s_d.mem.addr  = s_q.base[s_q.slot] + woff;
          s_d.mem.wdata = '0;
        end
        else if (MEM_ACK_IN)
        begin
          s_d.loc[s_q.slot][s_q.wcnt] = MEM_RDATA_IN;
          s_d.mem.req = 1'b0;
          s_d.wcnt    = s_q.wcnt + 1'b1;
          if (s_q.wcnt == `RFC_LAST_WORD)
            s_d.st = rfc_pkg::RFC_ST_IDLE;
        end
      end
      default:
        s_d.st = rfc_pkg::RFC_ST_IDLE;
    endcase
    s_d.busy = (s_d.st != rfc_pkg::RFC_ST_IDLE);
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      s_q        <= '0;
      s_q.cached <= `RFC_ONE;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================
  // Address generator
  rfc_agen u_agen
  (
    .clk_in      (CLK_IN),
    .rst_in      (RST_IN),
    .valid_in    (AG_VALID_IN),
    .req_in      (AG_IN),
    .base_val_in (word_of(s_q, AG_IN.base_sel)),
    .idx_val_in  (word_of(s_q, AG_IN.idx_sel)),
    .ea_out      (AG_EA_OUT),
    .valid_out   (AG_VALID_OUT),
    .fault_out   (AG_FAULT_OUT)
  );

  assign BUSY_OUT          = s_q.busy;
  assign UNDERFLOW_OUT     = s_q.under;
  assign FRAME_POINTER_OUT = s_q.glob[`RFC_FP_IDX];
  assign RD_A_DATA_OUT     = s_q.rd_a;
  assign RD_B_DATA_OUT     = s_q.rd_b;
  assign EXT_RD_DATA_OUT   = s_q.ext_rd;
  assign MEM_OUT           = s_q.mem;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence seq_call_idle;
    s_q.st == rfc_pkg::RFC_ST_IDLE && OP_VALID_IN && OP_IN == rfc_pkg::RFC_OP_CALL;
  endsequence
  sequence seq_spill_last;
    s_q.st == rfc_pkg::RFC_ST_SPILL && s_q.mem.req && MEM_ACK_IN
      && s_q.wcnt == `RFC_LAST_WORD;
  endsequence

  AST_FULL_SPILLS: assert property (
    seq_call_idle and s_q.cached == `RFC_FULL |=> BUSY_OUT ##2 MEM_OUT.req && MEM_OUT.we)
    else $error("full call did not spill");
  AST_CALL_NO_MEM: assert property (
    seq_call_idle and s_q.cached < `RFC_FULL |=> !BUSY_OUT && !MEM_OUT.req
      && s_q.cached == $past(s_q.cached) + 1'b1)
    else $error("cached call touched memory");
  AST_GLOBALS_KEPT: assert property (
    seq_call_idle and !WR_IN.en and !EXT_WR_EN_IN |=>
      s_q.glob == $past(s_q.glob) && s_q.ext == $past(s_q.ext))
    else $error("call changed globals");
  AST_FRESH_FRAME: assert property (
    seq_call_idle and s_q.cached < `RFC_FULL |=>
      s_q.loc[s_q.cur][`RFC_LAST_WORD] == '0 && s_q.cur == $past(s_q.cur) + 1'b1)
    else $error("new frame not fresh");
  AST_CACHE_RANGE: assert property (
    s_q.cached >= `RFC_ONE && s_q.cached <= `RFC_FULL)
    else $error("frame count out of range");
  AST_SPILL_ADDR: assert property (
    s_q.st == rfc_pkg::RFC_ST_SPILL && s_q.mem.req |->
      MEM_OUT.addr == s_q.base[s_q.slot] + {s_q.wcnt, {`RFC_BYTE_SH{1'b0}}})
    else $error("spill address wrong");
  AST_RET_FILL: assert property (
    s_q.st == rfc_pkg::RFC_ST_IDLE && OP_VALID_IN && OP_IN == rfc_pkg::RFC_OP_RET
      && s_q.cached == `RFC_ONE && s_q.depth != '0 |=> BUSY_OUT ##1 MEM_OUT.req && !MEM_OUT.we)
    else $error("return did not refill");
  AST_FLUSH_END: assert property (
    seq_spill_last and s_q.pend == rfc_pkg::RFC_OP_FLUSH
      and s_q.cached == (`RFC_ONE + `RFC_ONE) |=>
      !BUSY_OUT && s_q.cached == `RFC_ONE)
    else $error("flush did not stop at one frame");

endmodule

// File: sim/rfc_mem_model.sv
`timescale 1ns/10ps
`include "rfc_defines.svh"

module rfc_mem_model
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // Stack port
  input  wire rfc_pkg::rfc_mem_t mem_in,
  input  wire logic [1:0]        lat_in,
  output logic                   ack_out,
  output logic [`RFC_W-1:0]      rdata_out
);
  // ==========================================
  // Storage
  logic [`RFC_W-1:0] mem [logic [`RFC_W-1:0]];
  int                n_wr = 0;
  int                n_rd = 0;
  logic [1:0]        cnt;
  logic              drop;

  // ==========================================
  // Handshake
  // Idle data toggles, so a late sample never sees a stale word
  always @(posedge clk_in)
  begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (rst_in)
    begin
      cnt <= 2'h0;
      drop <= 1'b0;
      rdata_out <= '0;
    end
    else if (drop)
      drop <= mem_in.req;
    else if (mem_in.req && cnt != lat_in)
      cnt <= cnt + 2'h1;
    else if (mem_in.req)
    begin
      ack_out <= 1'b1;
      drop <= 1'b1;
      cnt <= 2'h0;
      if (mem_in.we)
      begin
        mem[mem_in.addr] = mem_in.wdata;
        n_wr++;
      end
      else
      begin
        rdata_out <= mem.exists(mem_in.addr) ? mem[mem_in.addr] : '0;
        n_rd++;
      end
    end
  end
endmodule

// File: sim/tb.sv
`timescale 1ns/10ps
`include "rfc_defines.svh"

module tb;
  // ==========================================
  // Signals
  logic                  CLK_IN = 1'b0;
  logic                  RST_IN = 1'b1;
  logic                  OP_VALID_IN = 1'b0;
  rfc_pkg::rfc_op_t      OP_IN = rfc_pkg::RFC_OP_NONE;
  rfc_pkg::rfc_rd_t      RD_A_IN = '0;
  rfc_pkg::rfc_rd_t      RD_B_IN = '0;
  rfc_pkg::rfc_wr_t      WR_IN = '0;
  logic [1:0]            EXT_RD_IDX_IN = '0;
  logic [1:0]            EXT_WR_IDX_IN = '0;
  logic                  EXT_WR_EN_IN = 1'b0;
  logic [79:0]           EXT_WR_DATA_IN = '0;
  logic                  AG_VALID_IN = 1'b0;
  rfc_pkg::rfc_ag_t      AG_IN = '0;
  logic                  BUSY_OUT, UNDERFLOW_OUT, AG_VALID_OUT, AG_FAULT_OUT, MEM_ACK_IN;
  logic [31:0]           FRAME_POINTER_OUT, AG_EA_OUT, MEM_RDATA_IN;
  logic [3:0][31:0]      RD_A_DATA_OUT, RD_B_DATA_OUT, qa, qb;
  logic [79:0]           EXT_RD_DATA_OUT;
  rfc_pkg::rfc_mem_t     MEM_OUT;
  int                    fail_count = 0;
  int                    n_compared = 0;
  int                    seed = 32'ha5a14673;
  logic [31:0]           g [16];
  logic [79:0]           e [4];
  logic [31:0]           v5, ea, b, x, d;
  logic [11:0]           o;
  logic [2:0]            s;
  logic [1:0]            lat = 2'h0;
  logic                  uf, bz;

  always #5 CLK_IN = ~CLK_IN;
  always @(posedge CLK_IN) lat <= 2'($random(seed));

  rfc_top i_dut (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .OP_VALID_IN(OP_VALID_IN), .OP_IN(OP_IN),
    .BUSY_OUT(BUSY_OUT), .UNDERFLOW_OUT(UNDERFLOW_OUT), .FRAME_POINTER_OUT(FRAME_POINTER_OUT),
    .RD_A_IN(RD_A_IN), .RD_A_DATA_OUT(RD_A_DATA_OUT), .RD_B_IN(RD_B_IN),
    .RD_B_DATA_OUT(RD_B_DATA_OUT), .WR_IN(WR_IN), .EXT_RD_IDX_IN(EXT_RD_IDX_IN),
    .EXT_RD_DATA_OUT(EXT_RD_DATA_OUT), .EXT_WR_EN_IN(EXT_WR_EN_IN),
    .EXT_WR_IDX_IN(EXT_WR_IDX_IN), .EXT_WR_DATA_IN(EXT_WR_DATA_IN), .AG_VALID_IN(AG_VALID_IN),
    .AG_IN(AG_IN), .AG_EA_OUT(AG_EA_OUT), .AG_VALID_OUT(AG_VALID_OUT),
    .AG_FAULT_OUT(AG_FAULT_OUT), .MEM_OUT(MEM_OUT), .MEM_ACK_IN(MEM_ACK_IN),
    .MEM_RDATA_IN(MEM_RDATA_IN));

  rfc_mem_model i_mem (.clk_in(CLK_IN), .rst_in(RST_IN), .mem_in(MEM_OUT), .lat_in(lat),
    .ack_out(MEM_ACK_IN), .rdata_out(MEM_RDATA_IN));

  // ==========================================
  // Tasks
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [31:0] xt(input logic [31:0] v, input int t);
    case (t)
      1: return {24'h0, v[7:0]};
      2: return {{24{v[7]}}, v[7:0]};
      3: return {16'h0, v[15:0]};
      4: return {{16{v[15]}}, v[15:0]};
      default: return v;
    endcase
  endfunction

  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge CLK_IN);
    WR_IN <= '{en: 1'b1, addr: a, len: 2'h0, data: {96'h0, v}};
    @(posedge CLK_IN);
    WR_IN <= '0;
  endtask

  // Both read ports get the same request
  task automatic rd(input logic [4:0] a, input logic [1:0] l, input int t);
    @(posedge CLK_IN);
    RD_A_IN <= '{addr: a, len: l, ty: rfc_pkg::rfc_type_t'(t)};
    RD_B_IN <= '{addr: a, len: l, ty: rfc_pkg::rfc_type_t'(t)};
    @(negedge CLK_IN);
    @(negedge CLK_IN);
    qa = RD_A_DATA_OUT;
    qb = RD_B_DATA_OUT;
  endtask

  task automatic echk(input int i);
    @(posedge CLK_IN);
    EXT_RD_IDX_IN <= 2'(i);
    @(negedge CLK_IN);
    @(negedge CLK_IN);
    chk(EXT_RD_DATA_OUT, e[i]);
  endtask

  // Bounded wait; a stuck spill counts as a mismatch
  task automatic op(input rfc_pkg::rfc_op_t c);
    @(posedge CLK_IN);
    OP_VALID_IN <= 1'b1;
    OP_IN <= c;
    @(posedge CLK_IN);
    OP_VALID_IN <= 1'b0;
    @(negedge CLK_IN);
    uf = UNDERFLOW_OUT;
    bz = BUSY_OUT;
    for (int n = 0; n < 2000 && BUSY_OUT !== 1'b0; n++)
      @(negedge CLK_IN);
    if (BUSY_OUT !== 1'b0)
    begin
      fail_count++;
      $display("[FAIL] %0t busy stuck", $time);
    end
  endtask

  // ==========================================
  // Watchdog
  initial
  begin
    #200000;
    fail_count++;
    $display("[FAIL] %0t timeout", $time);
    finish_test();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    repeat (10) @(posedge CLK_IN);
    RST_IN <= 1'b0;
    @(negedge CLK_IN);
    chk({BUSY_OUT, UNDERFLOW_OUT, FRAME_POINTER_OUT}, '0);
    for (int i = 0; i < 16; i++)
    begin
      g[i] = $random(seed);
      wr(5'h10 | 5'(i), g[i]);
    end
    for (int i = 0; i < 16; i++)
    begin
      rd(5'h10 | 5'(i), 2'(i), i % 5);
      for (int k = 0; k < 4; k++)
        chk({qa[k], qb[k]}, {2{k > i % 4 ? 32'h0 : k == 0 ? xt(g[i], i % 5) : g[(i + k) % 16]}});
    end
    chk(FRAME_POINTER_OUT, g[15]);
    for (int i = 0; i < 4; i++)
    begin
      e[i] = 80'({$random(seed), $random(seed), $random(seed)});
      @(posedge CLK_IN);
      EXT_WR_EN_IN <= 1'b1;
      EXT_WR_IDX_IN <= 2'(i);
      EXT_WR_DATA_IN <= e[i];
    end
    @(posedge CLK_IN);
    EXT_WR_EN_IN <= 1'b0;
    for (int i = 0; i < 4; i++)
      echk(i);
    // Every mode once, then an illegal scale
    for (int m = 0; m < 9; m++)
    begin
      s = m == 8 ? 3'h5 + 3'($unsigned($random(seed)) % 3) : 3'($unsigned($random(seed)) % 5);
      o = 12'($random(seed));
      d = $random(seed);
      @(posedge CLK_IN);
      AG_VALID_IN <= 1'b1;
      AG_IN <= '{mode: rfc_pkg::rfc_amode_t'(m % 8), scale: s, off12: o, disp: d,
                 base_sel: 5'h13, idx_sel: 5'h14};
      @(posedge CLK_IN);
      AG_VALID_IN <= 1'b0;
      @(negedge CLK_IN);
      b = g[3];
      x = g[4] << s;
      case (m % 8)
        0: ea = 32'(o);
        1: ea = d;
        2: ea = b;
        3: ea = b + 32'(o);
        4: ea = b + d;
        5: ea = b + x;
        6: ea = x + d;
        default: ea = b + x + d;
      endcase
      if (m < 8)
        chk({AG_VALID_OUT, AG_FAULT_OUT, AG_EA_OUT}, {2'b10, ea});
      else
        chk({AG_VALID_OUT, AG_FAULT_OUT}, 2'b11);
    end
    v5 = $random(seed);
    wr(5'h05, v5);
    for (int k = 0; k < 4; k++)
    begin
      g[15] = 32'(k + 1) << 12;
      wr(5'h1f, g[15]);
      op(rfc_pkg::RFC_OP_CALL);
      chk({bz, FRAME_POINTER_OUT}, {k == 3, g[15]});
      if (k == 0)
      begin
        rd(5'h00, 2'h0, 0);
        chk(qa[0], g[15]);
        rd(5'h04, 2'h3, 0);
        chk({qa[1], qb[1]}, 64'h0);
      end
    end
    chk(i_mem.n_wr, 16);
    chk(i_mem.mem[32'h1014], v5);
    op(rfc_pkg::RFC_OP_FLUSH);
    chk(i_mem.n_wr, 64);
    chk(i_mem.mem[32'h2000], 32'h1000);
    rd(5'h13, 2'h0, 0);
    chk({qa[0], qb[0]}, {2{g[3]}});
    echk(1);
    repeat (4) op(rfc_pkg::RFC_OP_RET);
    chk(i_mem.n_rd, 64);
    rd(5'h05, 2'h0, 0);
    chk({qa[0], qb[0]}, {2{v5}});
    op(rfc_pkg::RFC_OP_RET);
    chk({uf, bz}, 2'b10);
    // Cached return and empty flush must not touch memory
    op(rfc_pkg::RFC_OP_NONE);
    chk({uf, bz, FRAME_POINTER_OUT}, {2'b00, g[15]});
    op(rfc_pkg::RFC_OP_CALL);
    chk(bz, 1'b0);
    wr(5'h05, ~v5);
    op(rfc_pkg::RFC_OP_RET);
    rd(5'h05, 2'h0, 0);
    chk({bz, qa[0]}, {1'b0, v5});
    chk(i_mem.n_rd, 64);
    op(rfc_pkg::RFC_OP_FLUSH);
    chk(bz, 1'b0);
    chk(i_mem.n_wr, 64);
    finish_test();
  end
endmodule
